/* File: common/tacc_defines.svh */
/*
  Register offset, field positions, reset value and timing counts of the
  touch converter conversion control.
  Assumes a 100 MHz core clock and an 8-bit serial register address.
*/
`ifndef TACC_DEFINES_SVH
`define TACC_DEFINES_SVH

// ==========================================================================
// Register map
`define TACC_ADDR_W            8
`define TACC_REG_W             16
`define TACC_CTRL1_ADDR        8'h01
`define TACC_CTRL1_RST         16'h0000

// ==========================================================================
// Field positions of conversion_control_one
`define TACC_TMR_MSB           7
`define TACC_TMR_LSB           0
`define TACC_ACQ_MSB           9
`define TACC_ACQ_LSB           8
`define TACC_MODE_MSB          11
`define TACC_MODE_LSB          10
`define TACC_CHAN_MSB          14
`define TACC_CHAN_LSB          12
`define TACC_IRQ_OFF_BIT       15

// ==========================================================================
// Timing
`define TACC_CLK_PERIOD_NS     10
`define TACC_INTERVAL_BASE_US  550
`define TACC_INTERVAL_STEP_US  35
`define TACC_INTERVAL_BASE_CYC ((`TACC_INTERVAL_BASE_US * 1000) / `TACC_CLK_PERIOD_NS)
`define TACC_INTERVAL_STEP_CYC ((`TACC_INTERVAL_STEP_US * 1000) / `TACC_CLK_PERIOD_NS)
`define TACC_ACQ_BASE_CYC      4
`define TACC_TIMER_CNT_W       20
`define TACC_DATA_W            12

`endif

/* File: common/tacc_pkg.sv */
/*
  Types of the touch converter conversion control: operating modes,
  input channel codes and sequencer states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tacc_pkg;

  // ========================================================================
  // Operating modes, in field order 00, 01, 10, 11
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_SINGLE,
    MODE_SLAVE_SEQ,
    MODE_MASTER_SEQ
  } tacc_mode_t;

  // ========================================================================
  // Input codes; each equals its sequencer enable bit position
  typedef enum logic [2:0] {
    CH_INVALID     = 3'h0,
    CH_DIE_THERMAL = 3'h1,
    CH_BATTERY     = 3'h2,
    CH_SPARE       = 3'h3,
    CH_PRESSURE_B  = 3'h4,
    CH_PRESSURE_A  = 3'h5,
    CH_YPLUS       = 3'h6,
    CH_XPLUS       = 3'h7
  } tacc_chan_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_TOUCH,
    ST_PICK,
    ST_ACQ,
    ST_CONV,
    ST_DONE,
    ST_INTERVAL
  } tacc_state_t;

endpackage : tacc_pkg

/* File: common/tacc_timer_if.sv */
/*
  Link between the conversion sequencer and its interval timer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps

interface tacc_timer_if;
  logic       start;
  logic       stop;
  logic [7:0] code;
  logic       expired;

  modport ctrl  (output start, output stop, output code, input expired);
  modport timer (input start, input stop, input code, output expired);
endinterface : tacc_timer_if

/* File: verilog/tacc_interval_timer.sv */
/*
  Repeat interval timer: loads the interval for a nonzero code on start,
  counts down and pulses expired once.
  Assumes stop and start are never raised for a zero code together.
*/
`timescale 1ns/10ps
`include "tacc_defines.svh"

module tacc_interval_timer
  import tacc_pkg::*;
#(
  parameter int BASE_CYC = `TACC_INTERVAL_BASE_CYC,
  parameter int STEP_CYC = `TACC_INTERVAL_STEP_CYC,
  parameter int CNT_W    = `TACC_TIMER_CNT_W
) (
  input  wire logic    core_clk_in,
  input  wire logic    rst_in,
  tacc_timer_if.timer  tif
);

  // ========================================================================
  // Checks
  if (BASE_CYC < 1 || STEP_CYC < 0 ||
      (BASE_CYC + 254 * STEP_CYC) >= (1 << CNT_W)) begin : g_chk
    $error("interval counter too narrow or bad interval");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic             run_ff;
  logic             expired_ff;

  function automatic logic [CNT_W-1:0] load_value(input logic [7:0] code);
    return CNT_W'(BASE_CYC + (int'(code) - 1) * STEP_CYC - 1);
  endfunction : load_value

  // ========================================================================
  // Countdown
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_ff     <= '0;
      run_ff     <= 1'b0;
      expired_ff <= 1'b0;
    end else if (tif.stop) begin
      run_ff     <= 1'b0;
      expired_ff <= 1'b0;
    end else if (tif.start) begin
      cnt_ff     <= load_value(tif.code);
      run_ff     <= 1'b1;
      expired_ff <= 1'b0;
    end else if (run_ff && cnt_ff == '0) begin
      run_ff     <= 1'b0;
      expired_ff <= 1'b1;
    end else begin
      cnt_ff     <= run_ff ? cnt_ff - 1'b1 : cnt_ff;
      expired_ff <= 1'b0;
    end
  end

  assign tif.expired = expired_ff;

  // ========================================================================
  // Assertions
  property p_interval_load;
    @(posedge core_clk_in) disable iff (rst_in)
    (tif.start && !tif.stop) |=>
      (cnt_ff == CNT_W'(BASE_CYC + (int'($past(tif.code)) - 1) * STEP_CYC - 1));
  endproperty
  a_interval_load: assert property (p_interval_load)
    else $error("interval load value wrong");

endmodule : tacc_interval_timer

/* File: verilog/tacc_conv_ctrl.sv */
/*
  Conversion control of a touch-screen sampling converter: holds
  conversion_control_one, sequences single and multi-channel conversions,
  runs the repeat interval and drives the shared interrupt output.
  Assumes synchronous inputs, a converter that answers each conv_start
  with one adc_done pulse, and the other control registers as plain inputs.
*/
// Functional notes
// - interval_code 1 means 550 us, each step adds 35 us, up to 9.440 ms.
// - interval_code zero, the default, runs the conversion or sequence once.
// - In slave modes the interval starts as soon as a sequence completes.
// - In master mode the interval starts only if still touched at sequence end.
// - In master mode a release stops the interval; next touch starts at once.
// - sample_window_sel picks 4, 8, 16 or 32 acquisition periods, default 4.
// - conv_mode_sel: 00 idle, 01 single slave, 10 slave sequence, 11 master.
// - Single-channel mode converts only the input named by input_select.
// - One-shot single or slave sequence clears mode to idle when finished.
// - Nonzero interval repeats single or slave sequence, mode left unchanged.
// - Slave sequence converts each enabled channel not dropped by the GPIO/battery rule below and stores each result.
// - Master mode waits on wake-on-touch; no sequence until the panel is touched.
// - Master mode restarts only on a fresh touch or expiry while touched.
// - single_ended_sel set gives single-ended, clear gives ratiometric conversion.
// - With touch_irq_off clear, the shared output goes low while touched.
// - With touch_irq_off set, the shared output shows the limit interrupt.
// - input codes 7..1: X+, Y+, pressure_a, pressure_b, spare, battery, thermal.
// - conversion_control_one resets to all zeros.
// - Sequencer bits 7..1 enable the same channels as codes 7..1; bit 0 unused.
// - GPIO enabled skips spare and battery; both selected measures battery only.
`timescale 1ns/10ps
`include "tacc_defines.svh"

module tacc_conv_ctrl
  import tacc_pkg::*;
#(
  parameter int INTERVAL_BASE_CYC = `TACC_INTERVAL_BASE_CYC,
  parameter int INTERVAL_STEP_CYC = `TACC_INTERVAL_STEP_CYC,
  parameter int DATA_W            = `TACC_DATA_W
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  input  wire logic [`TACC_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`TACC_REG_W-1:0]   reg_wdata_in,
  output logic      [`TACC_REG_W-1:0]   reg_rdata_out,
  input  wire logic [7:0]               seq_enable_in,
  input  wire logic                     gpio_enable_in,
  input  wire logic                     single_ended_sel_in,
  input  wire logic                     touch_in,
  input  wire logic                     limit_irq_in,
  input  wire logic                     adc_done_in,
  input  wire logic [DATA_W-1:0]        adc_data_in,
  output logic                          acq_active_out,
  output logic                          conv_start_out,
  output logic      [2:0]               conv_chan_out,
  output logic                          conv_single_ended_out,
  output logic                          result_wr_out,
  output logic      [2:0]               result_chan_out,
  output logic      [DATA_W-1:0]        result_data_out,
  output logic                          wake_on_touch_out,
  output logic                          irq_n_out
);

  // ========================================================================
  // Checks
  if (DATA_W < 1 || DATA_W > `TACC_REG_W) begin : g_chk
    $error("DATA_W out of range");
  end

  // ========================================================================
  // Declarations
  logic [`TACC_REG_W-1:0] ctrl_ff;
  tacc_state_t            state_ff;
  logic [7:0]             pending_ff;
  logic [5:0]             acq_cnt_ff;
  logic                   released_ff;
  logic                   acq_active_ff;
  logic                   conv_start_ff;
  logic [2:0]             chan_ff;
  logic                   single_ended_ff;
  logic                   result_wr_ff;
  logic [2:0]             result_chan_ff;
  logic [DATA_W-1:0]      result_data_ff;
  logic                   wake_ff;
  logic                   irq_n_ff;
  logic [`TACC_REG_W-1:0] rdata_ff;
  logic                   ctrl_wr;
  tacc_mode_t             mode;
  tacc_mode_t             nxt_mode;
  logic [7:0]             tmr_code;
  logic                   one_shot;
  logic                   timer_start;
  logic                   timer_stop;
  tacc_timer_if tif ();

  // ========================================================================
  // Helpers
  function automatic logic is_ctrl1(input logic [`TACC_ADDR_W-1:0] addr);
    return addr == `TACC_CTRL1_ADDR;
  endfunction : is_ctrl1
  function automatic logic [2:0] top_bit(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : top_bit
  // Channels still to convert when a conversion or sequence begins
  function automatic logic [7:0] start_mask(input tacc_mode_t m_sel,
                                            input logic [2:0] chan,
                                            input logic [7:0] seq,
                                            input logic       gpio_en);
    logic [7:0] m;
    m = 8'h00;
    if (m_sel == MODE_SINGLE) begin
      m[chan] = (chan != CH_INVALID);
    end else if (m_sel != MODE_IDLE) begin
      m = seq & 8'hFE;
      if (gpio_en) begin
        m[CH_SPARE]   = 1'b0;
        m[CH_BATTERY] = 1'b0;
      end else if (m[CH_SPARE] && m[CH_BATTERY]) begin
        m[CH_SPARE] = 1'b0;
      end
    end
    return m;
  endfunction : start_mask
  assign ctrl_wr  = reg_wr_in && is_ctrl1(reg_addr_in);
  assign mode     = tacc_mode_t'(ctrl_ff[`TACC_MODE_MSB:`TACC_MODE_LSB]);
  assign nxt_mode = tacc_mode_t'(reg_wdata_in[`TACC_MODE_MSB:`TACC_MODE_LSB]);
  assign tmr_code = ctrl_ff[`TACC_TMR_MSB:`TACC_TMR_LSB];
  assign one_shot = (tmr_code == 8'h00);

  // ========================================================================
  // Control register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_ff <= `TACC_CTRL1_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= reg_wdata_in;
    end else if (state_ff == ST_DONE && one_shot && mode != MODE_MASTER_SEQ) begin
      ctrl_ff[`TACC_MODE_MSB:`TACC_MODE_LSB] <= MODE_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd_in) begin
      rdata_ff <= is_ctrl1(reg_addr_in) ? ctrl_ff : 16'h0000;
    end
  end

  // ========================================================================
  // Touch tracking for fresh-touch starts
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      released_ff <= 1'b0;
    end else if (ctrl_wr || !touch_in) begin
      released_ff <= 1'b1;
    end else if (state_ff == ST_WAIT_TOUCH) begin
      released_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Sequencer
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff      <= ST_IDLE;
      pending_ff    <= 8'h00;
      chan_ff       <= 3'h0;
      acq_cnt_ff    <= 6'h00;
      acq_active_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end else if (ctrl_wr) begin
      acq_active_ff <= 1'b0;
      conv_start_ff <= 1'b0;
      pending_ff    <= start_mask(nxt_mode,
                                  reg_wdata_in[`TACC_CHAN_MSB:`TACC_CHAN_LSB],
                                  seq_enable_in, gpio_enable_in);
      unique case (nxt_mode)
        MODE_IDLE:       state_ff <= ST_IDLE;
        MODE_SINGLE:     state_ff <= ST_PICK;
        MODE_SLAVE_SEQ:  state_ff <= ST_PICK;
        MODE_MASTER_SEQ: state_ff <= ST_WAIT_TOUCH;
      endcase
    end else begin
      conv_start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: pending_ff <= 8'h00;
        ST_WAIT_TOUCH: begin
          if (touch_in && released_ff) begin
            state_ff   <= ST_PICK;
            pending_ff <= start_mask(mode, ctrl_ff[`TACC_CHAN_MSB:`TACC_CHAN_LSB],
                                     seq_enable_in, gpio_enable_in);
          end
        end
        ST_PICK: begin
          if (pending_ff == 8'h00) begin
            state_ff <= ST_DONE;
          end else begin
            chan_ff                      <= top_bit(pending_ff);
            pending_ff[top_bit(pending_ff)] <= 1'b0;
            acq_cnt_ff <= 6'(`TACC_ACQ_BASE_CYC << ctrl_ff[`TACC_ACQ_MSB:`TACC_ACQ_LSB]) - 6'h01;
            acq_active_ff <= 1'b1;
            state_ff      <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (acq_cnt_ff == 6'h00) begin
            acq_active_ff <= 1'b0;
            conv_start_ff <= 1'b1;
            state_ff      <= ST_CONV;
          end else begin
            acq_cnt_ff <= acq_cnt_ff - 6'h01;
          end
        end
        ST_CONV: state_ff <= adc_done_in ? ST_PICK : ST_CONV;
        ST_DONE: begin
          if (mode == MODE_MASTER_SEQ) begin
            state_ff <= (touch_in && !one_shot) ? ST_INTERVAL : ST_WAIT_TOUCH;
          end else begin
            state_ff <= one_shot ? ST_IDLE : ST_INTERVAL;
          end
        end
        ST_INTERVAL: begin
          if (mode == MODE_MASTER_SEQ && !touch_in) begin
            state_ff <= ST_WAIT_TOUCH;
          end else if (tif.expired) begin
            state_ff   <= ST_PICK;
            pending_ff <= start_mask(mode, ctrl_ff[`TACC_CHAN_MSB:`TACC_CHAN_LSB],
                                     seq_enable_in, gpio_enable_in);
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Interval timer
  assign timer_start = !ctrl_wr && state_ff == ST_DONE && !one_shot &&
                       (mode != MODE_MASTER_SEQ || touch_in);
  assign timer_stop  = ctrl_wr ||
                       (state_ff == ST_INTERVAL && mode == MODE_MASTER_SEQ && !touch_in);
  assign tif.start   = timer_start;
  assign tif.stop    = timer_stop;
  assign tif.code    = tmr_code;
  tacc_interval_timer #(
    .BASE_CYC (INTERVAL_BASE_CYC),
    .STEP_CYC (INTERVAL_STEP_CYC),
    .CNT_W    (`TACC_TIMER_CNT_W)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tif         (tif.timer)
  );

  // ========================================================================
  // Results
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      result_wr_ff   <= 1'b0;
      result_chan_ff <= 3'h0;
      result_data_ff <= '0;
    end else begin
      result_wr_ff <= (state_ff == ST_CONV) && adc_done_in && !ctrl_wr;
      if (state_ff == ST_CONV && adc_done_in) begin
        result_chan_ff <= chan_ff;
        result_data_ff <= adc_data_in;
      end
    end
  end

  // ========================================================================
  // Pin-facing outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      single_ended_ff <= 1'b0;
      wake_ff         <= 1'b0;
      irq_n_ff        <= 1'b1;
    end else begin
      single_ended_ff <= single_ended_sel_in;
      wake_ff         <= (mode == MODE_MASTER_SEQ);
      if (ctrl_ff[`TACC_IRQ_OFF_BIT]) begin
        irq_n_ff <= !limit_irq_in;
      end else begin
        irq_n_ff <= !touch_in;
      end
    end
  end
  assign reg_rdata_out         = rdata_ff;
  assign acq_active_out        = acq_active_ff;
  assign conv_start_out        = conv_start_ff;
  assign conv_chan_out         = chan_ff;
  assign conv_single_ended_out = single_ended_ff;
  assign result_wr_out         = result_wr_ff;
  assign result_chan_out       = result_chan_ff;
  assign result_data_out       = result_data_ff;
  assign wake_on_touch_out     = wake_ff;
  assign irq_n_out             = irq_n_ff;

  // ========================================================================
  // Assertions
  property p_touch_irq;
    @(posedge core_clk_in) disable iff (rst_in)
    (!ctrl_ff[`TACC_IRQ_OFF_BIT] && !ctrl_wr) |=> (irq_n_out == !$past(touch_in));
  endproperty
  a_touch_irq: assert property (p_touch_irq)
    else $error("touch interrupt does not follow touch");
  property p_limit_irq;
    @(posedge core_clk_in) disable iff (rst_in)
    (ctrl_ff[`TACC_IRQ_OFF_BIT] && !ctrl_wr) |=> (irq_n_out == !$past(limit_irq_in));
  endproperty
  a_limit_irq: assert property (p_limit_irq)
    else $error("shared output does not show limit interrupt");
  property p_no_invalid_conv;
    @(posedge core_clk_in) disable iff (rst_in)
    conv_start_out |-> (conv_chan_out != 3'h0);
  endproperty
  a_no_invalid_conv: assert property (p_no_invalid_conv)
    else $error("conversion started on invalid code");
  property p_one_shot_idle;
    @(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_DONE && one_shot && !ctrl_wr &&
     (mode == MODE_SINGLE || mode == MODE_SLAVE_SEQ))
      |=> (mode == MODE_IDLE && state_ff == ST_IDLE);
  endproperty
  a_one_shot_idle: assert property (p_one_shot_idle)
    else $error("one-shot did not return to idle");
  sequence s_acq4;
    acq_active_out [*4] ##1 (!acq_active_out && conv_start_out);
  endsequence
  property p_acq_len;
    @(posedge core_clk_in) disable iff (rst_in || reg_wr_in)
    ($rose(acq_active_out) && ctrl_ff[`TACC_ACQ_MSB:`TACC_ACQ_LSB] == 2'b00) |-> s_acq4;
  endproperty
  a_acq_len: assert property (p_acq_len)
    else $error("acquisition length wrong for code 00");
  property p_wait_touch;
    @(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_WAIT_TOUCH && !touch_in && !ctrl_wr) |=>
      (state_ff == ST_WAIT_TOUCH && !acq_active_out);
  endproperty
  a_wait_touch: assert property (p_wait_touch)
    else $error("sequence started without touch");
  property p_release_stop;
    @(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_INTERVAL && mode == MODE_MASTER_SEQ && !touch_in && !ctrl_wr)
      |=> (state_ff == ST_WAIT_TOUCH);
  endproperty
  a_release_stop: assert property (p_release_stop)
    else $error("release did not stop interval");
  property p_slave_repeat;
    @(posedge core_clk_in) disable iff (rst_in)
    (state_ff == ST_DONE && !one_shot && !ctrl_wr && mode != MODE_MASTER_SEQ)
      |=> (state_ff == ST_INTERVAL && mode == $past(mode));
  endproperty
  a_slave_repeat: assert property (p_slave_repeat)
    else $error("slave interval did not start");

endmodule : tacc_conv_ctrl

/* File: verification/tacc_adc_model.sv */
/*
  Converter model: answers each conv_start with one done pulse after a
  programmable wait, data carrying the channel code.
  Assumes the core clock and synchronous reset of the control block.
*/
`timescale 1ns/10ps

module tacc_adc_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        conv_start_in,
  input  wire logic [2:0]  conv_chan_in,
  input  wire logic [3:0]  delay_in,
  output logic             adc_done_out,
  output logic [11:0]      adc_data_out
);
  logic [3:0] cnt_ff;
  logic       busy_ff;

  always_ff @(posedge core_clk_in) begin
    adc_done_out <= 1'b0;
    // Data outside the done pulse keeps toggling, never stale
    adc_data_out <= ~adc_data_out;
    if (rst_in) begin
      busy_ff      <= 1'b0;
      cnt_ff       <= 4'h0;
      adc_data_out <= 12'h000;
    end else if (conv_start_in) begin
      busy_ff <= 1'b1;
      cnt_ff  <= delay_in;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff      <= 1'b0;
      adc_done_out <= 1'b1;
      adc_data_out <= {9'h0A5, conv_chan_in};
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule : tacc_adc_model

/* File: verification/testbench.sv */
/*
  Self-checking bench of tacc_conv_ctrl with a converter model.
  Assumes shortened interval parameters of 20 and 5 cycles.
*/
`timescale 1ns/10ps

module testbench;
  import tacc_pkg::*;
  logic core_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, gpio_enable_in = 0;
  logic single_ended_sel_in = 0, touch_in = 0, limit_irq_in = 0, adc_done_in;
  logic [7:0]  reg_addr_in = 0, seq_enable_in = 0;
  logic [15:0] reg_wdata_in = 0, reg_rdata_out, r;
  logic [11:0] adc_data_in, result_data_out;
  logic [3:0]  adc_wait = 4'h3;
  logic [2:0]  conv_chan_out, result_chan_out, got[$];
  logic acq_active_out, conv_start_out, conv_single_ended_out, result_wr_out;
  logic wake_on_touch_out, irq_n_out;
  int mismatches, checked, cycles, acq_n, p[2], stamp[$];

  tacc_conv_ctrl #(.INTERVAL_BASE_CYC(20), .INTERVAL_STEP_CYC(5)) dut (
    .core_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .seq_enable_in, .gpio_enable_in, .single_ended_sel_in, .touch_in,
    .limit_irq_in, .adc_done_in, .adc_data_in, .acq_active_out, .conv_start_out,
    .conv_chan_out, .conv_single_ended_out, .result_wr_out, .result_chan_out,
    .result_data_out, .wake_on_touch_out, .irq_n_out);
  tacc_adc_model model (.core_clk_in, .rst_in, .conv_start_in(conv_start_out),
    .conv_chan_in(conv_chan_out), .delay_in(adc_wait), .adc_done_out(adc_done_in),
    .adc_data_out(adc_data_in));

  always #5 core_clk_in = ~core_clk_in;

  // ==========================================================================
  // Monitor and timeout
  always @(posedge core_clk_in) begin
    cycles++;
    if (acq_active_out === 1'b1) acq_n++;
    if (result_wr_out === 1'b1) begin
      got.push_back(result_chan_out);
      stamp.push_back(cycles);
    end
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    cyc(1);
    reg_wr_in = 0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd_in = 1;
    reg_addr_in = a;
    cyc(1);
    reg_rd_in = 0;
    cyc(1);
    r = reg_rdata_out;
  endtask : rd
  task automatic clr();
    got.delete();
    stamp.delete();
    acq_n = 0;
  endtask : clr
  task automatic run(input logic [15:0] d);
    clr();
    wr(8'h01, d);
    for (int i = 0; i < 150; i++) begin
      rd(8'h01);
      if (r[11:10] === 2'b00) break;
    end
  endtask : run
  task automatic chk_seq(input logic [2:0] e[$], input string m);
    chk(got.size() == e.size(), m);
    foreach (e[i]) if (i < got.size()) chk(got[i] === e[i], m);
  endtask : chk_seq

  // ==========================================================================
  // Scenarios
  initial begin
    cyc(2);
    rst_in = 0;
    t_regs();
    t_single();
    t_seq();
    t_repeat();
    t_master();
    t_irq();
    report_and_stop();
  end
  task automatic t_regs();
    rd(8'h01);
    chk(r === 16'h0000, "reset value");
    wr(8'h02, 16'h0C55);
    rd(8'h02);
    chk(r === 16'h0000, "unmapped read");
    rd(8'h01);
    chk(r === 16'h0000, "unmapped write");
    touch_in = 1;
    cyc(2);
    chk(irq_n_out === 1'b0, "touch irq");
    touch_in = 0;
  endtask : t_regs
  task automatic t_single();
    single_ended_sel_in = 1;
    for (int k = 1; k < 8; k++) begin
      run({1'b0, k[2:0], 2'h1, k[1:0], 8'h00});
      chk(acq_n == (4 << (k % 4)), "acq length");
      chk(got.size() == 1 && got[0] === k[2:0], "single chan");
      chk(result_data_out === {9'h0A5, k[2:0]}, "result data");
      chk(r[11:10] === 2'b00, "mode clear");
    end
    chk(conv_single_ended_out === 1'b1, "single-ended");
    single_ended_sel_in = 0;
    cyc(2);
    chk(conv_single_ended_out === 1'b0, "ratiometric");
    run(16'h0400);
    chk(got.size() == 0 && acq_n == 0, "invalid code");
  endtask : t_single
  task automatic t_seq();
    seq_enable_in = 8'hFF;
    adc_wait = 4'h9;
    run(16'h0800);
    chk_seq('{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1}, "seq order");
    gpio_enable_in = 1;
    run(16'h0800);
    chk_seq('{3'h7, 3'h6, 3'h5, 3'h4, 3'h1}, "gpio skip");
    gpio_enable_in = 0;
  endtask : t_seq
  task automatic t_repeat();
    adc_wait = 4'h3;
    seq_enable_in = 8'h02;
    for (int j = 0; j < 2; j++) begin
      clr();
      wr(8'h01, {8'h08, 6'h00, j[0], 1'b1});
      cyc(200);
      rd(8'h01);
      chk(r[11:10] === 2'b10 && got.size() >= 3, "repeat");
      p[j] = stamp[2] - stamp[1];
      wr(8'h01, 16'h0000);
      cyc(10);
    end
    chk(p[1] - p[0] == 10, "interval step");
  endtask : t_repeat
  task automatic t_master();
    seq_enable_in = 8'h80;
    clr();
    wr(8'h01, 16'h0C00);
    cyc(20);
    chk(wake_on_touch_out === 1'b1 && got.size() == 0, "wait touch");
    touch_in = 1;
    cyc(40);
    chk(got.size() == 1, "touch start");
    cyc(40);
    chk(got.size() == 1, "no repeat");
    touch_in = 0;
    cyc(5);
    touch_in = 1;
    cyc(40);
    chk(got.size() == 2, "retouch");
    touch_in = 0;
    wr(8'h01, 16'h0000);
    clr();
    wr(8'h01, 16'h0C01);
    touch_in = 1;
    cyc(20);
    touch_in = 0;
    cyc(100);
    chk(got.size() == 1, "release stops");
  endtask : t_master
  task automatic t_irq();
    wr(8'h01, 16'h8000);
    limit_irq_in = 1;
    cyc(2);
    chk(irq_n_out === 1'b0, "limit irq");
    touch_in = 1;
    limit_irq_in = 0;
    cyc(2);
    chk(irq_n_out === 1'b1, "touch masked");
  endtask : t_irq
endmodule : testbench
